/* File: verilog/rtc_pkg.sv */
`default_nettype none
// ============================================================
// shared constants and types of the compensated timebase
package rtc_pkg;
  // register addresses on the host register port
  localparam logic [7:0] RTC_ADDR_TEMP   = 8'h20;  // temperature_reading
  localparam logic [7:0] RTC_ADDR_CONFIG = 8'h30;  // sensor_clockout_config
  localparam logic [7:0] RTC_ADDR_TRIM   = 8'h31;  // crystal_ppm_trim
  // reset values (code 3ch is 0 degrees)
  localparam logic [7:0] RTC_TEMP_RESET   = 8'h3c;
  localparam logic [7:0] RTC_CONFIG_RESET = 8'h00;
  localparam logic [7:0] RTC_TRIM_RESET   = 8'h00;
  // field positions
  localparam int RTC_CFG_SCAN_BIT   = 0;  // scan_interval_select
  localparam int RTC_CFG_ENABLE_BIT = 1;  // thermometer enable
  localparam int RTC_TRIM_SIGN_BIT  = 7;  // 1 = crystal runs fast
  // reference and period figures
  localparam int RTC_REF_HZ          = 32768;  // reference ticks per second
  localparam int RTC_PERIOD_S        = 32;     // compensation period, seconds
  localparam int RTC_SCAN_SLOW_S     = 16;     // slow scan interval, seconds
  localparam int RTC_PRESCALE_W      = 15;     // log2 of RTC_REF_HZ
  localparam int RTC_ACC_W           = 20;     // log2 of ticks per period
  localparam int RTC_SEC_W           = 5;      // log2 of RTC_PERIOD_S
  localparam int RTC_SCAN_W          = 4;      // log2 of RTC_SCAN_SLOW_S
  localparam logic [RTC_SEC_W-1:0]  RTC_SEC_LAST  = 5'(RTC_PERIOD_S - 1);
  localparam logic [RTC_SCAN_W-1:0] RTC_SCAN_SLOW = 4'(RTC_SCAN_SLOW_S - 1);
  localparam logic [RTC_SCAN_W-1:0] RTC_SCAN_FAST = 4'h0;
  // temperature code offset: code minus 60 is degrees, t0 field plus 4 is degrees
  localparam logic signed [9:0] RTC_DT_BIAS = 10'sh040;  // 60 + 4
  localparam int RTC_COEF_SHIFT = 12;                    // coefficient scale 4096
  localparam int RTC_COMP_W     = 11;                    // signed pulses per period
  localparam logic signed [12:0] RTC_COMP_MAX = 13'sh03ff;
  // prescaler advance per reference tick
  localparam logic [1:0] RTC_STEP_SKIP   = 2'h0;
  localparam logic [1:0] RTC_STEP_NORMAL = 2'h1;
  localparam logic [1:0] RTC_STEP_INSERT = 2'h2;

  // one host register access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtc_reg_req_t;

  // thermometer sequencer
  typedef enum logic [0:0] {
    RTC_SCAN_IDLE = 1'b0,
    RTC_SCAN_BUSY = 1'b1
  } rtc_scan_state_t;
endpackage : rtc_pkg
`default_nettype wire

/* File: verilog/rtc_drift_corrector.sv */
`default_nettype none
// ============================================================
// drift_corrector: pulses per period from trim, coefficient and temperature
module rtc_drift_corrector
  import rtc_pkg::*;
(
  input  wire logic                         clk_in,        // system clock
  input  wire logic                         rst_n_in,      // async reset, active low
  input  wire logic                         load_in,       // recompute strobe
  input  wire logic [7:0]                   temp_in,       // temperature code
  input  wire logic [7:0]                   trim_in,       // sign and magnitude
  input  wire logic [7:0]                   coef_in,       // quadratic coefficient
  input  wire logic [5:0]                   turnover_in,   // turnover field
  output logic signed [RTC_COMP_W-1:0]      comp_out       // signed pulses per period
);
  logic signed [9:0]  dt;        // temperature minus turnover, degrees
  logic        [15:0] dt_sq;     // squared difference
  logic        [23:0] drift_raw; // coefficient times square
  logic signed [12:0] sum;       // combined correction before clamp
  logic signed [RTC_COMP_W-1:0] next_comp;

  // ============================================================
  // combinational value; a slow crystal needs added pulses
  always_comb
  begin
    dt        = $signed({2'b00, temp_in}) - $signed({4'h0, turnover_in}) - RTC_DT_BIAS;
    // widen before multiplying, a self-sized product would lose its upper bits
    dt_sq     = 16'(20'(dt) * 20'(dt));
    drift_raw = 24'(coef_in) * 24'(dt_sq);
    // the quadratic drift always slows the crystal, so it adds pulses
    sum = $signed({1'b0, 12'(drift_raw >> RTC_COEF_SHIFT)});
    // fast crystal removes pulses, slow crystal adds them
    if (trim_in[RTC_TRIM_SIGN_BIT])
      sum = sum - $signed({6'h00, trim_in[6:0]});
    else
      sum = sum + $signed({6'h00, trim_in[6:0]});
    // clamp: the result must fit the signed RTC_COMP_W field, at most 1023 either way
    if (sum > RTC_COMP_MAX)
      next_comp = RTC_COMP_W'(RTC_COMP_MAX);
    else if (sum < -RTC_COMP_MAX)
      next_comp = RTC_COMP_W'(-RTC_COMP_MAX);
    else
      next_comp = RTC_COMP_W'(sum);
    // hold between strobes
    if (!load_in)
      next_comp = comp_out;
  end

  // ============================================================
  // value only moves on the strobe
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      comp_out <= '0;
    else
      comp_out <= next_comp;
  end
endmodule // rtc_drift_corrector
`default_nettype wire

/* File: verilog/rtc_comp_timebase.sv */
`default_nettype none
// How it works
// - recompute correction every 32 seconds
// - add or swallow reference ticks
// - spread pulses across whole 32 s period
// - config bit 1 enables thermometer
// - config bit 0 picks 1 s or 16 s
// - measurement result stored at 20h
// - code zero is -60, 3ch is 0
// - one degree per code step
// - low supply level one stops measuring
// - frozen reading keeps feeding compensation
// - resume only after both flags cleared
// - trim bit 7 gives correction direction
// - trim bits 6..0 magnitude, up to 121; stored unclamped, so up to 127 reaches the corrector
// - trim cancels offset at turnover
// - corrections act on first divider stage
// - one pulse per period is one ppm
module rtc_comp_timebase
  import rtc_pkg::*;
(
  input  wire logic                    clk_in,                 // 50 mhz system clock
  input  wire logic                    rst_n_in,               // async reset, active low
  input  wire rtc_reg_req_t            reg_req_in,             // host register access
  output logic [7:0]                   reg_rdata_out,          // read data, one cycle later
  input  wire logic                    osc_tick_in,            // one pulse per 32.768 khz tick
  input  wire logic [7:0]              temp_sample_in,         // thermometer result
  input  wire logic                    temp_valid_in,          // result strobe
  input  wire logic                    low_supply1_status_in,  // first low-supply flag
  input  wire logic                    low_supply2_status_in,  // second low-supply flag
  input  wire logic [7:0]              coef_in,                // factory quadratic coefficient
  input  wire logic [5:0]              turnover_in,            // factory turnover field
  output logic                         meas_start_out,         // start one measurement
  output logic                         therm_active_out,       // thermometer running
  output logic                         second_tick_out,        // compensated 1 hz pulse
  output logic signed [RTC_COMP_W-1:0] comp_value_out          // current pulses per period
);
  // ============================================================
  // state
  logic [7:0]          temp_reg;     // temperature_reading
  logic [7:0]          config_reg;   // sensor_clockout_config
  logic [7:0]          trim_reg;     // crystal_ppm_trim
  logic                low_stop;     // measurements held off by low supply
  rtc_scan_state_t     scan_state;   // measurement in flight or not
  logic [RTC_SCAN_W-1:0] scan_cnt;   // seconds into the scan interval
  logic [RTC_PRESCALE_W-1:0] prescale; // first divider stage
  logic [RTC_SEC_W-1:0] sec_cnt;     // seconds into the period
  logic [RTC_ACC_W-1:0] spread_acc;  // pulse spreading accumulator
  logic                load_comp;    // recompute strobe

  logic [7:0]          next_temp_reg, next_config_reg, next_trim_reg, next_rdata;
  logic                next_low_stop, next_meas_start;
  rtc_scan_state_t     next_scan_state;
  logic [RTC_SCAN_W-1:0] next_scan_cnt;
  logic [RTC_PRESCALE_W-1:0] next_prescale;
  logic [RTC_SEC_W-1:0] next_sec_cnt;
  logic [RTC_ACC_W-1:0] next_spread_acc;
  logic                next_second, next_load;

  // ============================================================
  // helpers of the two groups, each used by only one of them
  logic                therm_on;     // enabled and not held off
  logic [RTC_SCAN_W-1:0] scan_last;  // last second of the interval
  logic [RTC_ACC_W:0]  acc_sum;      // accumulator with carry
  logic [RTC_COMP_W-2:0] comp_mag;   // magnitude of correction
  logic [1:0]          step;         // prescaler advance this tick
  logic [RTC_PRESCALE_W:0] pre_sum;  // prescaler with carry

  assign therm_on  = config_reg[RTC_CFG_ENABLE_BIT] && !low_stop;
  assign scan_last = config_reg[RTC_CFG_SCAN_BIT] ? RTC_SCAN_SLOW : RTC_SCAN_FAST;
  assign comp_mag  = comp_value_out[RTC_COMP_W-1] ? (RTC_COMP_W-1)'(-comp_value_out)
                                                  : comp_value_out[RTC_COMP_W-2:0];

  // ============================================================
  // register file and thermometer sequencer, next values
  always_comb
  begin
    next_temp_reg   = temp_reg;
    next_config_reg = config_reg;
    next_trim_reg   = trim_reg;
    next_rdata      = reg_rdata_out;
    next_low_stop   = low_stop;
    next_scan_state = scan_state;
    next_scan_cnt   = scan_cnt;
    next_meas_start = 1'b0;
    // the hold only lifts once software cleared both flags
    if (low_supply1_status_in)
      next_low_stop = 1'b1;
    else if (!low_supply2_status_in)
      next_low_stop = 1'b0;
    // host reads: one registered answer, unmapped reads give zero
    if (reg_req_in.rd)
    begin
      unique case (reg_req_in.addr)
        RTC_ADDR_TEMP:   next_rdata = temp_reg;
        RTC_ADDR_CONFIG: next_rdata = config_reg;
        RTC_ADDR_TRIM:   next_rdata = trim_reg;
        default:         next_rdata = 8'h00;
      endcase
    end
    // host writes; factory values are writable, software is asked not to
    if (reg_req_in.wr)
    begin
      unique case (reg_req_in.addr)
        // temperature write only lands while the thermometer enable bit is clear
        RTC_ADDR_TEMP:   if (!config_reg[RTC_CFG_ENABLE_BIT]) next_temp_reg = reg_req_in.wdata;
        RTC_ADDR_CONFIG: next_config_reg = reg_req_in.wdata;
        // magnitude is stored as written, range kept by software
        RTC_ADDR_TRIM:   next_trim_reg = reg_req_in.wdata;
        default:         ;
      endcase
    end
    // count seconds of the scan interval
    if (next_second)
    begin
      if (scan_cnt >= scan_last)
        next_scan_cnt = '0;
      else
        next_scan_cnt = scan_cnt + 1'b1;
    end
    unique case (scan_state)
      RTC_SCAN_IDLE:
        // start a scan when the interval elapses
        if (therm_on && next_second && scan_cnt >= scan_last)
        begin
          next_meas_start = 1'b1;
          next_scan_state = RTC_SCAN_BUSY;
        end
      RTC_SCAN_BUSY:
        // a stopped thermometer drops the scan and the old code stays
        if (!therm_on)
          next_scan_state = RTC_SCAN_IDLE;
        else if (temp_valid_in)
        begin
          // store result whole in one cycle
          // offset code, one degree per step
          next_temp_reg   = temp_sample_in;
          next_scan_state = RTC_SCAN_IDLE;
        end
    endcase
  end

  // ============================================================
  // register file and sequencer flops
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      temp_reg       <= RTC_TEMP_RESET;
      config_reg     <= RTC_CONFIG_RESET;
      trim_reg       <= RTC_TRIM_RESET;
      reg_rdata_out  <= 8'h00;
      low_stop       <= 1'b0;
      scan_state     <= RTC_SCAN_IDLE;
      scan_cnt       <= '0;
      meas_start_out <= 1'b0;
    end
    else
    begin
      temp_reg       <= next_temp_reg;
      config_reg     <= next_config_reg;
      trim_reg       <= next_trim_reg;
      reg_rdata_out  <= next_rdata;
      low_stop       <= next_low_stop;
      scan_state     <= next_scan_state;
      scan_cnt       <= next_scan_cnt;
      meas_start_out <= next_meas_start;
    end
  end

  // ============================================================
  // compensated divider, next values
  always_comb
  begin
    next_spread_acc = spread_acc;
    next_sec_cnt    = sec_cnt;
    next_load       = 1'b0;
    step            = RTC_STEP_NORMAL;
    // accumulator spreads the count evenly over the period's ticks
    acc_sum = {1'b0, spread_acc} + {{(RTC_ACC_W - RTC_COMP_W + 2){1'b0}}, comp_mag};
    if (osc_tick_in)
    begin
      next_spread_acc = acc_sum[RTC_ACC_W-1:0];
      // a carry inserts or swallows one tick
      // one carry per period shifts time by about one ppm
      if (acc_sum[RTC_ACC_W])
        step = comp_value_out[RTC_COMP_W-1] ? RTC_STEP_SKIP : RTC_STEP_INSERT;
    end
    else
      step = RTC_STEP_SKIP;
    // corrections enter the first stage, so only a second in which a carry falls moves
    pre_sum       = {1'b0, prescale} + {{(RTC_PRESCALE_W - 1){1'b0}}, step};
    next_prescale = pre_sum[RTC_PRESCALE_W-1:0];
    next_second   = pre_sum[RTC_PRESCALE_W];
    if (next_second)
    begin
      if (sec_cnt == RTC_SEC_LAST)
      begin
        next_sec_cnt    = '0;
        next_load       = 1'b1;
        next_spread_acc = '0;
      end
      else
        next_sec_cnt = sec_cnt + 1'b1;
    end
  end

  // ============================================================
  // divider flops
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prescale        <= '0;
      sec_cnt         <= '0;
      spread_acc      <= '0;
      load_comp       <= 1'b0;
      second_tick_out <= 1'b0;
    end
    else
    begin
      prescale        <= next_prescale;
      sec_cnt         <= next_sec_cnt;
      spread_acc      <= next_spread_acc;
      load_comp       <= next_load;
      second_tick_out <= next_second;
    end
  end

  rtc_drift_corrector u_corrector (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .load_in     (load_comp),
    .temp_in     (temp_reg),
    .trim_in     (trim_reg),
    .coef_in     (coef_in),
    .turnover_in (turnover_in),
    .comp_out    (comp_value_out)
  );

  assign therm_active_out = therm_on;

  // ============================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence wrap_s;
    second_tick_out && sec_cnt == '0;
  endsequence
  sequence carry_s;
    osc_tick_in && acc_sum[RTC_ACC_W];
  endsequence

  period_recompute_a: assert property (wrap_s |-> load_comp)
    else $error("recompute strobe missing at period wrap");
  insert_step_a: assert property ((carry_s and !comp_value_out[RTC_COMP_W-1]) |=>
                                  prescale == $past(prescale) + 2'd2)
    else $error("inserted tick did not advance twice");
  spread_reset_a: assert property (load_comp |-> spread_acc == '0)
    else $error("spreader not restarted with the period");
  disabled_idle_a: assert property (!config_reg[RTC_CFG_ENABLE_BIT] |=> !meas_start_out)
    else $error("measurement started while disabled");
  slow_scan_a: assert property (meas_start_out && config_reg[RTC_CFG_SCAN_BIT] && $stable(config_reg)
                                |-> $past(scan_cnt) == RTC_SCAN_SLOW)
    else $error("slow scan started early");
  result_store_a: assert property (scan_state == RTC_SCAN_BUSY && therm_on && temp_valid_in
                                   |=> temp_reg == $past(temp_sample_in))
    else $error("measurement not stored");
  low_supply_stop_a: assert property (low_supply1_status_in |=> !therm_active_out ##1 !meas_start_out)
    else $error("thermometer ran under low supply");
  frozen_reading_a: assert property (low_stop && !reg_req_in.wr |=> $stable(temp_reg))
    else $error("frozen temperature changed");
  resume_hold_a: assert property (low_stop && low_supply2_status_in |=> low_stop)
    else $error("resumed before flags cleared");
  write_blocked_a: assert property (reg_req_in.wr && reg_req_in.addr == RTC_ADDR_TEMP
                                    && config_reg[RTC_CFG_ENABLE_BIT] && scan_state == RTC_SCAN_IDLE
                                    |=> $stable(temp_reg))
    else $error("temperature write landed while enabled");
endmodule // rtc_comp_timebase
`default_nettype wire

/* File: test/rtc_comp_timebase_tb_top.sv */
`default_nettype none
// ============================================================
// self-checking bench of the compensated timebase
module rtc_comp_timebase_tb_top
  import rtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                         clk_in = 1'b0;          // 50 mhz system clock
  logic                         rst_n_in;               // async reset, active low
  rtc_reg_req_t                 reg_req_in;             // host access
  logic [7:0]                   reg_rdata_out;          // read data
  logic                         osc_tick_in;            // reference tick
  logic [7:0]                   temp_sample_in;         // thermometer result
  logic                         temp_valid_in;          // result strobe
  logic                         low_supply1_status_in;  // first low-supply flag
  logic                         low_supply2_status_in;  // second low-supply flag
  logic [7:0]                   coef_in;                // factory coefficient
  logic [5:0]                   turnover_in;            // factory turnover
  logic                         meas_start_out;         // measurement start
  logic                         therm_active_out;       // thermometer running
  logic                         second_tick_out;        // compensated 1 hz
  logic signed [RTC_COMP_W-1:0] comp_value_out;         // pulses per period
  int                           n_errors = 0;           // mismatches seen
  int                           checks = 0;             // comparisons made
  int                           model_reg [3];          // temp, config, trim as software expects them
  logic [7:0]                   rd_val;                 // last read result
  logic [7:0]                   sample;                 // last accepted thermometer code

  // ============================================================
  // clock: toggles every half period
  always #10 clk_in = ~clk_in;

  rtc_comp_timebase u_dut (
    .clk_in                (clk_in),
    .rst_n_in              (rst_n_in),
    .reg_req_in            (reg_req_in),
    .reg_rdata_out         (reg_rdata_out),
    .osc_tick_in           (osc_tick_in),
    .temp_sample_in        (temp_sample_in),
    .temp_valid_in         (temp_valid_in),
    .low_supply1_status_in (low_supply1_status_in),
    .low_supply2_status_in (low_supply2_status_in),
    .coef_in               (coef_in),
    .turnover_in           (turnover_in),
    .meas_start_out        (meas_start_out),
    .therm_active_out      (therm_active_out),
    .second_tick_out       (second_tick_out),
    .comp_value_out        (comp_value_out)
  );

  // ============================================================
  // comparison and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ============================================================
  // model: what a read should return; unmapped places read zero
  function automatic logic [7:0] model_read(input logic [7:0] addr);
    case (addr)
      RTC_ADDR_TEMP:   return 8'(model_reg[0]);
      RTC_ADDR_CONFIG: return 8'(model_reg[1]);
      RTC_ADDR_TRIM:   return 8'(model_reg[2]);
      default:         return 8'h00;
    endcase
  endfunction

  // one write, driven at the falling edge; the model drops temperature writes while enabled
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_in);
    reg_req_in = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
    if (addr == RTC_ADDR_TEMP && model_reg[1][RTC_CFG_ENABLE_BIT] == 0)
      model_reg[0] = data;
    if (addr == RTC_ADDR_CONFIG)
      model_reg[1] = data;
    if (addr == RTC_ADDR_TRIM)
      model_reg[2] = data;
    @(negedge clk_in);
    reg_req_in = '0;
  endtask

  // one read; data is registered at the rd edge and sampled at the next falling edge
  task automatic reg_read(input logic [7:0] addr);
    @(negedge clk_in);
    reg_req_in = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
    @(negedge clk_in);
    reg_req_in = '0;
    rd_val = reg_rdata_out;
  endtask

  // read back every mapped place plus one unmapped address
  task automatic read_all();
    logic [7:0] addrs [4];
    addrs = '{RTC_ADDR_TEMP, RTC_ADDR_CONFIG, RTC_ADDR_TRIM, 8'h21};
    foreach (addrs[i])
    begin
      reg_read(addrs[i]);
      check(rd_val, model_read(addrs[i]));
    end
  endtask

  // one thermometer result strobe
  task automatic send_result(input logic [7:0] code);
    @(negedge clk_in);
    temp_sample_in = code;
    temp_valid_in  = 1'b1;
    @(negedge clk_in);
    temp_valid_in  = 1'b0;
    temp_sample_in = ~code;
  endtask

  // ticks every cycle until the compensated second; with zero correction it is 32768 ticks long
  task automatic run_second(input logic exp_meas);
    int n;
    n = 0;
    @(negedge clk_in);
    osc_tick_in = 1'b1;
    while (second_tick_out !== 1'b1 && n < 40000)
    begin
      @(negedge clk_in);
      n++;
      if (second_tick_out !== 1'b1 && meas_start_out !== 1'b0)
        check(meas_start_out, 1'b0);
    end
    osc_tick_in = 1'b0;
    check(n, RTC_REF_HZ);
    check(meas_start_out, exp_meas);
    check(32'(comp_value_out), 32'h0);
  endtask

  // ============================================================
  // main sequence
  initial
  begin
    void'($urandom(32'h4d06eb92));
    rst_n_in              = 1'b0;
    reg_req_in            = '0;
    osc_tick_in           = 1'b0;
    temp_sample_in        = 8'h00;
    temp_valid_in         = 1'b0;
    low_supply1_status_in = 1'b0;
    low_supply2_status_in = 1'b0;
    coef_in               = 8'($urandom);
    turnover_in           = 6'($urandom);
    model_reg             = '{32'h3c, 32'h00, 32'h00};
    repeat (4) @(negedge clk_in);
    rst_n_in = 1'b1;
    // reset state and register reset values
    check(therm_active_out, 1'b0);
    check(32'(comp_value_out), 32'h0);
    read_all();
    // trim keeps sign and magnitude; software keeps magnitude within 0..121
    reg_write(RTC_ADDR_TRIM, {1'($urandom), 7'($urandom_range(121, 0))});
    reg_write(RTC_ADDR_TEMP, 8'($urandom));
    reg_write(8'h22, 8'hff);
    read_all();
    // enabling; a temperature write now must be dropped
    reg_write(RTC_ADDR_CONFIG, 8'h02);
    check(therm_active_out, 1'b1);
    reg_write(RTC_ADDR_TEMP, 8'($urandom));
    read_all();
    // low-supply hold: released only when both flags are clear
    low_supply1_status_in = 1'b1;
    @(negedge clk_in);
    check(therm_active_out, 1'b0);
    low_supply1_status_in = 1'b0;
    low_supply2_status_in = 1'b1;
    @(negedge clk_in);
    check(therm_active_out, 1'b0);
    low_supply2_status_in = 1'b0;
    @(negedge clk_in);
    check(therm_active_out, 1'b1);
    // first second: measurement starts, result lands in the register
    run_second(1'b1);
    repeat (3) @(negedge clk_in);
    sample = 8'($urandom);
    send_result(sample);
    model_reg[0] = sample;
    read_all();
    // second second under low supply: no start, reading frozen
    low_supply1_status_in = 1'b1;
    @(negedge clk_in);
    check(therm_active_out, 1'b0);
    send_result(~sample);
    run_second(1'b0);
    read_all();
    low_supply1_status_in = 1'b0;
    @(negedge clk_in);
    check(therm_active_out, 1'b1);
    // slow scan select is stored and keeps the thermometer on
    reg_write(RTC_ADDR_CONFIG, 8'h03);
    check(therm_active_out, 1'b1);
    read_all();
    report_and_stop();
  end

  // ============================================================
  // watchdog: two seconds of ticks plus register traffic fit well inside this span
  initial
  begin
    repeat (90000) @(posedge clk_in);
    n_errors++;
    report_and_stop();
  end
endmodule // rtc_comp_timebase_tb_top
`default_nettype wire
